// >>> hdl/uas_ir_shaper.sv
/*
 * uas_ir_shaper: infrared pulse shaper between channel and pins.
 * assumes: tick_i is the 16x oversampling enable, ref_tick_i the
 * infrared reference clock enable, both one-cycle pulses.
 */
`timescale 1ns/1ns
module uas_ir_shaper
    import uas_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic ref_tick_i,
    input wire logic prop_i,
    input wire logic tx_serial_i,
    input wire logic ir_rx_i,
    output logic ir_tx_o,
    output logic rx_serial_o
);
    logic tx_prev_q; // last serial level
    logic [3:0] tx_cnt_q; // pulse length left
    logic [3:0] tx_ph_q; // ticks into the current bit
    logic tx_start; // a zero bit begins
    logic rx_prev_q; // last ir level
    logic [4:0] rx_cnt_q; // stretch ticks left

    // a zero bit begins on a falling edge or sixteen ticks into a low run
    assign tx_start = !tx_serial_i && (tx_prev_q || (tick_i && tx_ph_q == 4'hF)); // [R18]

    // bit phase, realigned on each falling serial edge
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            tx_ph_q <= 4'h0;
        else if (tx_prev_q && !tx_serial_i)
            tx_ph_q <= 4'h0;
        else if (tick_i)
            tx_ph_q <= tx_ph_q + 4'h1;
    end

    // start a high pulse at each zero bit start
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            tx_prev_q <= 1'b1;
            tx_cnt_q <= 4'h0;
            ir_tx_o <= 1'b0;
        end
        else
        begin
            tx_prev_q <= tx_serial_i;
            if (tx_start)
            begin
                // every zero bit begins a pulse, also back to back [R18]
                tx_cnt_q <= prop_i ? IR_PROP_TICKS : 4'(IR_FIXED_REF_PERIODS); // [R19]
                ir_tx_o <= 1'b1;
            end
            else if (tx_cnt_q != 4'h0 && (prop_i ? tick_i : ref_tick_i))
            begin
                // count down in ticks or reference periods [R23] [R24]
                tx_cnt_q <= tx_cnt_q - 4'h1;
                ir_tx_o <= (tx_cnt_q != 4'h1);
            end
            else if (tx_cnt_q == 4'h0)
            begin
                ir_tx_o <= 1'b0;
            end
        end
    end

    // stretch each received pulse to a full low bit time [R17] [R24]
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            rx_prev_q <= 1'b0;
            rx_cnt_q <= 5'h00;
            rx_serial_o <= 1'b1;
        end
        else
        begin
            rx_prev_q <= ir_rx_i;
            if (!rx_prev_q && ir_rx_i)
            begin
                rx_cnt_q <= 5'(OVERSAMPLE);
                rx_serial_o <= 1'b0;
            end
            else if (rx_cnt_q != 5'h00 && tick_i)
            begin
                rx_cnt_q <= rx_cnt_q - 5'h01;
                rx_serial_o <= (rx_cnt_q == 5'h01);
            end
        end
    end
endmodule

// >>> hdl/uas_uart.sv
/*
 * uas_uart: async serial channel, 10-bit and 11-bit frame modes, with
 * infrared shaper control register.
 * assumes: register port is a single-cycle strobe interface; timer
 * rollovers arrive as one-cycle pulses on timer_roll_i.
 */
// Overview of operation
// [R1] ten-bit mode: buffer write loads marker one
// [R2] start after next divide-by-16 rollover
// [R3] start bit, then data, then shifting
// [R4] marker reached: final shift, done flag
// [R5] eleven-bit: ninth stage gets programmable bit
// [R6] ninth bit out: final shift, done flag
// [R7] 16x sampling; falling edge resets counter
// [R8] majority of samples seven, eight, nine
// [R9] nonzero start bit rejected, hunt again
// [R10] start at left end: shift, load
// [R11] ten-bit load needs flag clear, filter
// [R12] eleven-bit load needs flag clear, ninth
// [R13] hunt resumes one bit after shift; ten-bit mode hunts right after the final shift
// [R14] fixed mode /32 or /64; variable timer
// [R15] shaper use: ten-bit mode, equal rates
// [R16] shaper off after reset; bypass
// [R17] shaper sits between channel and pins
// [R18] zero bit becomes high pulse
// [R19] width select: fixed or 3/16
// [R20] control register layout, reset 0Fh
// [R21] supports 1.2 to 115.2 kbps
// [R22] divider must be 4 or more
// [R23] fixed pulse three reference periods
// [R24] proportional three ticks; stretch one bit
`timescale 1ns/1ns
module uas_uart
    import uas_pkg::*;
#(
    parameter int TIMER_TICKS = 1 // timer rollovers per sixteenth-bit
)
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire uas_reg_req_s reg_req_i,
    input wire logic timer_roll_i,
    input wire logic channel_two_in_pin_i,
    output logic channel_two_out_pin_o,
    output logic [7:0] reg_rdata_o
);
    initial
    begin
        if (TIMER_TICKS < 1 || TIMER_TICKS > 255)
            $error("TIMER_TICKS out of range");
    end

    logic [7:0] irc_q; // shaper control
    logic [7:0] scon_q; // serial control and flags
    logic [7:0] rx_buf_q; // received byte
    uas_mode_e mode;
    logic wr_buf, wr_scon, wr_irc;
    logic [7:0] pre_q; // core clocks or timer rollovers per tick
    logic tick_q; // sixteenth-bit enable
    logic [4:0] ref_cnt_q; // reference clock divider
    logic ref_tick_q; // reference clock enable
    logic [3:0] tx_div_q; // transmit divide-by-16
    logic tx_roll;
    logic [8:0] tx_sh_q; // transmit shift register
    logic tx_req_q; // pending transmission
    logic tx_go_q; // rollover seen, start next
    logic tx_send_q; // transmit active
    logic tx_data_q; // data routed to pin
    logic tx_first_q; // first shift inserts stop in 11-bit
    logic tx_line; // serial level from channel
    logic [3:0] rx_div_q; // receive divide-by-16
    logic [8:0] rx_sh_q; // receive shift register
    logic [2:0] rx_smp_q; // three samples
    logic rx_busy_q; // frame in progress
    logic rx_wait_q; // post-frame bit time
    logic rx_prev_q; // previous sampled level
    logic rx_line; // level seen by receiver
    logic shaped_tx, shaped_rx;
    logic vote;
    logic ten_mode;

    assign mode = uas_mode_e'(scon_q[SC_MODE_LSB +: 2]);
    assign ten_mode = (mode == UAS_MODE_TEN);
    assign wr_buf = reg_req_i.wr && reg_req_i.addr == SERIAL_BUFFER_ADDR;
    assign wr_scon = reg_req_i.wr && reg_req_i.addr == SERIAL_CONTROL_ADDR;
    assign wr_irc = reg_req_i.wr && reg_req_i.addr == IR_SHAPER_CONTROL_ADDR;

    // tick rate: fixed oscillator division or timer rollovers [R14]
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            pre_q <= 8'h00;
            tick_q <= 1'b0;
        end
        else
        begin
            tick_q <= 1'b0;
            if (mode == UAS_MODE_ELEVEN_FIXED)
            begin
                // /32 or /64 chosen by multiproc-free bit 4 of control [R14]
                if (pre_q >= (scon_q[4] ? 8'(FIXED_DIV64 - 1) : 8'(FIXED_DIV32 - 1)))
                begin
                    pre_q <= 8'h00;
                    tick_q <= 1'b1;
                end
                else
                    pre_q <= pre_q + 8'h01;
            end
            else if (timer_roll_i)
            begin
                if (pre_q >= 8'(TIMER_TICKS - 1))
                begin
                    pre_q <= 8'h00;
                    tick_q <= 1'b1;
                end
                else
                    pre_q <= pre_q + 8'h01;
            end
        end
    end

    // infrared reference clock from the five-bit divider
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            ref_cnt_q <= 5'h00;
            ref_tick_q <= 1'b0;
        end
        else if (ref_cnt_q >= irc_q[IRC_DIV_MSB:0])
        begin
            ref_cnt_q <= 5'h00;
            ref_tick_q <= 1'b1;
        end
        else
        begin
            ref_cnt_q <= ref_cnt_q + 5'h01;
            ref_tick_q <= 1'b0;
        end
    end

    // shaper control register, bit 7 reserved [R20] [R16]
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            irc_q <= IR_SHAPER_CONTROL_RST;
        else if (wr_irc)
            irc_q <= {1'b0, reg_req_i.wdata[6:0]};
    end

    // transmit divide-by-16, free running
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            tx_div_q <= 4'h0;
        else if (tick_q)
            tx_div_q <= tx_div_q + 4'h1;
    end
    assign tx_roll = tick_q && tx_div_q == 4'hF;

    // transmit controller
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            tx_sh_q <= 9'h000;
            tx_req_q <= 1'b0;
            tx_go_q <= 1'b0;
            tx_send_q <= 1'b0;
            tx_data_q <= 1'b0;
            tx_first_q <= 1'b0;
        end
        else if (wr_buf)
        begin
            // marker one or programmable ninth bit [R1] [R5]
            tx_sh_q <= {ten_mode ? 1'b1 : scon_q[SC_TX9_BIT], reg_req_i.wdata};
            tx_req_q <= 1'b1;
            tx_go_q <= 1'b0;
            tx_send_q <= 1'b0;
            tx_data_q <= 1'b0;
            tx_first_q <= 1'b1;
        end
        else if (tx_req_q && tx_roll)
            tx_go_q <= 1'b1; // wait for machine cycle after rollover [R2]
        else if (tx_go_q)
        begin
            // start bit goes out [R3]
            tx_go_q <= 1'b0;
            tx_req_q <= 1'b0;
            tx_send_q <= 1'b1;
        end
        else if (tx_send_q && tx_roll)
        begin
            if (!tx_data_q)
                tx_data_q <= 1'b1; // data routed one bit later [R3]
            else if (ten_mode && tx_sh_q[8:1] == 8'h01)
            begin
                // final shift after marker beside output [R4]
                tx_sh_q <= {1'b0, tx_sh_q[8:1]};
                tx_send_q <= 1'b0;
                tx_data_q <= 1'b0;
            end
            else if (!ten_mode && !tx_first_q && tx_sh_q[8:1] == 8'h01)
            begin
                // ninth bit out with stop beside it [R6]
                tx_sh_q <= {1'b0, tx_sh_q[8:1]};
                tx_send_q <= 1'b0;
                tx_data_q <= 1'b0;
            end
            else
            begin
                // zeros in from left, first shift inserts stop in 11-bit [R5]
                tx_sh_q <= {!ten_mode && tx_first_q, tx_sh_q[8:1]};
                tx_first_q <= 1'b0;
            end
        end
    end

    // serial line level from the channel
    assign tx_line = !tx_send_q ? 1'b1 : (tx_data_q ? tx_sh_q[0] : 1'b0);

    // pin bypass or shaper path [R16] [R17]
    uas_ir_shaper u_shaper (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .tick_i(tick_q),
        .ref_tick_i(ref_tick_q),
        .prop_i(irc_q[IRC_PULSE_BIT]),
        .tx_serial_i(tx_line),
        .ir_rx_i(channel_two_in_pin_i),
        .ir_tx_o(shaped_tx),
        .rx_serial_o(shaped_rx)
    );
    assign rx_line = irc_q[IRC_ENABLE_BIT] ? shaped_rx : channel_two_in_pin_i;

    // pin output register
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            channel_two_out_pin_o <= 1'b1;
        else
            channel_two_out_pin_o <= irc_q[IRC_ENABLE_BIT] ? shaped_tx : tx_line; // [R16]
    end

    // two of three vote [R8]
    assign vote = (rx_smp_q[0] & rx_smp_q[1]) | (rx_smp_q[0] & rx_smp_q[2])
                | (rx_smp_q[1] & rx_smp_q[2]);

    // receive controller
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            rx_div_q <= 4'h0;
            rx_sh_q <= RX_SHIFT_PRESET;
            rx_smp_q <= 3'b111;
            rx_busy_q <= 1'b0;
            rx_wait_q <= 1'b0;
            rx_prev_q <= 1'b1;
        end
        else if (tick_q)
        begin
            rx_prev_q <= rx_line; // 16x sampling [R7]
            if (!rx_busy_q && !rx_wait_q)
            begin
                if (rx_prev_q && !rx_line)
                begin
                    // falling edge: reset counter and preset [R7]
                    rx_div_q <= 4'h0;
                    rx_sh_q <= RX_SHIFT_PRESET;
                    rx_busy_q <= 1'b1;
                end
            end
            else
            begin
                rx_div_q <= rx_div_q + 4'h1;
                if (rx_div_q == SAMPLE_A) rx_smp_q[0] <= rx_line; // [R8]
                if (rx_div_q == SAMPLE_B) rx_smp_q[1] <= rx_line;
                if (rx_div_q == SAMPLE_C) rx_smp_q[2] <= rx_line;
                if (rx_div_q == 4'hF)
                begin
                    if (rx_wait_q)
                        rx_wait_q <= 1'b0; // back to hunting [R13]
                    else if (rx_sh_q == RX_SHIFT_PRESET && vote)
                        rx_busy_q <= 1'b0; // false start [R9]
                    else if (!rx_sh_q[8])
                    begin
                        // final shift, then hunt [R10] [R13]
                        rx_sh_q <= {rx_sh_q[7:0], vote};
                        rx_busy_q <= 1'b0;
                        rx_wait_q <= !ten_mode;
                    end
                    else
                        rx_sh_q <= {rx_sh_q[7:0], vote}; // in from right [R10]
                end
            end
        end
    end

    // serial control, flags and received byte
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            scon_q <= SERIAL_CONTROL_RST;
            rx_buf_q <= 8'h00;
        end
        else
        begin
            if (wr_scon)
                scon_q <= reg_req_i.wdata;
            // done flag set wins over software clear [R4] [R6]
            if (tx_send_q && tx_data_q && tx_roll && tx_sh_q[8:1] == 8'h01
                && (ten_mode || !tx_first_q))
                scon_q[SC_TXDONE_BIT] <= 1'b1;
            if (tick_q && rx_busy_q && !rx_wait_q && rx_div_q == 4'hF
                && !rx_sh_q[8] && !scon_q[SC_RXDONE_BIT]
                && (!scon_q[SC_MPF_BIT] || vote))
            begin
                // stop or ninth bit to SC_RX9_BIT [R11] [R12]
                // first data bit sits in stage 7, so the byte is mirrored
                rx_buf_q <= {rx_sh_q[0], rx_sh_q[1], rx_sh_q[2], rx_sh_q[3],
                             rx_sh_q[4], rx_sh_q[5], rx_sh_q[6], rx_sh_q[7]};
                scon_q[SC_RX9_BIT] <= vote;
                scon_q[SC_RXDONE_BIT] <= 1'b1;
            end
        end
    end

    // read data register
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            reg_rdata_o <= 8'h00;
        else if (reg_req_i.rd)
        begin
            unique case (reg_req_i.addr)
                SERIAL_BUFFER_ADDR: reg_rdata_o <= rx_buf_q;
                SERIAL_CONTROL_ADDR: reg_rdata_o <= scon_q;
                IR_SHAPER_CONTROL_ADDR: reg_rdata_o <= irc_q;
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end
endmodule

// >>> pkg/uas_pkg.sv
/*
 * uas_pkg: constants, modes and carrier types for the async serial block
 * with infrared pulse shaper.
 * assumes: single core clock, registers reached on a simple 8-bit
 * special-function-register port.
 */
package uas_pkg;
    // register map
    localparam logic [7:0] IR_SHAPER_CONTROL_ADDR = 8'hCE;
    localparam logic [7:0] IR_SHAPER_CONTROL_RST = 8'h0F;
    localparam int IRC_ENABLE_BIT = 6;
    localparam int IRC_PULSE_BIT = 5;
    localparam int IRC_DIV_MSB = 4;
    // own register offsets for the serial channel
    localparam logic [7:0] SERIAL_BUFFER_ADDR = 8'h99;
    localparam logic [7:0] SERIAL_CONTROL_ADDR = 8'h98;
    // serial control layout
    localparam int SC_MODE_LSB = 6;
    localparam int SC_MPF_BIT = 5;
    localparam int SC_TX9_BIT = 3;
    localparam int SC_RX9_BIT = 2;
    localparam int SC_TXDONE_BIT = 1;
    localparam int SC_RXDONE_BIT = 0;
    localparam logic [7:0] SERIAL_CONTROL_RST = 8'h40;
    // oversampling
    localparam int OVERSAMPLE = 16;
    localparam logic [3:0] SAMPLE_A = 4'h7;
    localparam logic [3:0] SAMPLE_B = 4'h8;
    localparam logic [3:0] SAMPLE_C = 4'h9;
    localparam logic [3:0] IR_PROP_TICKS = 4'h3;
    localparam int IR_FIXED_REF_PERIODS = 3;
    localparam logic [8:0] RX_SHIFT_PRESET = 9'h1FF;
    // fixed-rate dividers (core clocks per sixteenth-bit tick)
    localparam int FIXED_DIV32 = 2;
    localparam int FIXED_DIV64 = 4;

    typedef enum logic [1:0] {
        UAS_MODE_SHIFT,
        UAS_MODE_TEN,
        UAS_MODE_ELEVEN_FIXED,
        UAS_MODE_ELEVEN_VAR
    } uas_mode_e;

    // register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } uas_reg_req_s;
endpackage

// >>> testbench/tb_uas_uart.sv
/* tb_uas_uart: register-level test of the async serial block.
   assumes: 32 clocks a bit, from /32 or a rollover every second clock. */
`timescale 1ns/1ns
module tb_uas_uart
    import uas_pkg::*;
;
    logic clk_sys_i; // core clock
    logic rst_i; // sync reset
    uas_reg_req_s req; // register request
    logic roll = 1'b0; // timer rollovers
    logic pin_in; // device receive pin
    logic pin_out; // device transmit pin
    logic [7:0] rdata; // read data
    int miscompares;
    int samples_checked;
    logic [7:0] r; // read scratch
    logic [9:0] fr; // captured frame
    bit ok; // start bit seen before timeout
    int np; // pulse count
    uas_uart #(.TIMER_TICKS(1)) uut (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .reg_req_i(req),
        .timer_roll_i(roll),
        .channel_two_in_pin_i(pin_in),
        .channel_two_out_pin_o(pin_out),
        .reg_rdata_o(rdata)
    );
    uas_remote_dev #(.BIT_CLKS(32)) peer (
        .clk_i(clk_sys_i),
        .from_dut_i(pin_out),
        .to_dut_o(pin_in)
    );
    initial
    begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = !clk_sys_i;
    end
    // one rollover every second clock
    always @(posedge clk_sys_i) roll <= !roll;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys_i);
        req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_sys_i);
        req <= '0;
        @(negedge clk_sys_i);
        d = rdata;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        rd(a, r);
        chk8(r, exp);
    endtask
    task automatic close_out();
        if (miscompares == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // poll a control bit, bounded
    task automatic wait_bit(input int b);
        int t;
        t = 0;
        r = 8'h00;
        while (r[b] !== 1'b1 && t < 200)
        begin
            rd(SERIAL_CONTROL_ADDR, r);
            t++;
        end
        if (t >= 200)
        begin
            miscompares++;
            $display("BAD %0t flag wait ran out", $time);
            close_out();
        end
    endtask
    initial
    begin
        req = '0;
        rst_i = 1'b1;
        miscompares = 0;
        samples_checked = 0;
        repeat (5) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rchk(IR_SHAPER_CONTROL_ADDR, IR_SHAPER_CONTROL_RST);
        rchk(SERIAL_CONTROL_ADDR, SERIAL_CONTROL_RST);
        chk8({7'h00, pin_out}, 8'h01);
        wr(IR_SHAPER_CONTROL_ADDR, 8'hFF);
        rchk(IR_SHAPER_CONTROL_ADDR, 8'h7F);
        wr(IR_SHAPER_CONTROL_ADDR, 8'h0F);
        rchk(8'h42, 8'h00);
        // eleven-bit fixed rate, ninth bit one
        wr(SERIAL_CONTROL_ADDR, 8'h88);
        wr(SERIAL_BUFFER_ADDR, 8'hA5);
        peer.get(10, fr, ok);
        chk8({7'h00, ok}, 8'h01);
        chk8(fr[7:0], 8'hA5);
        chk8({6'h00, fr[9:8]}, 8'h03);
        wait_bit(SC_TXDONE_BIT);
        wr(SERIAL_CONTROL_ADDR, 8'h80);
        peer.send(9'h13C, 11, 1'b0);
        wait_bit(SC_RXDONE_BIT);
        rchk(SERIAL_BUFFER_ADDR, 8'h3C);
        rchk(SERIAL_CONTROL_ADDR, 8'h85);
        // flag still set: frame dropped
        peer.send(9'h155, 11, 1'b0);
        repeat (40) @(posedge clk_sys_i);
        rchk(SERIAL_BUFFER_ADDR, 8'h3C);
        // filter on: ninth bit zero dropped
        wr(SERIAL_CONTROL_ADDR, 8'hA0);
        peer.send(9'h011, 11, 1'b0);
        repeat (64) @(posedge clk_sys_i);
        peer.send(9'h122, 11, 1'b0);
        wait_bit(SC_RXDONE_BIT);
        rchk(SERIAL_BUFFER_ADDR, 8'h22);
        // false start ignored
        wr(SERIAL_CONTROL_ADDR, 8'h80);
        peer.glitch(6);
        repeat (64) @(posedge clk_sys_i);
        peer.send(9'h15A, 11, 1'b0);
        wait_bit(SC_RXDONE_BIT);
        rchk(SERIAL_BUFFER_ADDR, 8'h5A);
        // ten-bit mode on timer rollovers
        wr(SERIAL_CONTROL_ADDR, 8'h40);
        wr(SERIAL_BUFFER_ADDR, 8'h96);
        peer.get(9, fr, ok);
        chk8(fr[7:0], 8'h96);
        chk8({7'h00, fr[8]}, 8'h01);
        wait_bit(SC_TXDONE_BIT);
        peer.send(9'h1C3, 10, 1'b0);
        wait_bit(SC_RXDONE_BIT);
        rchk(SERIAL_BUFFER_ADDR, 8'hC3);
        rd(SERIAL_CONTROL_ADDR, r);
        chk8({7'h00, r[SC_RX9_BIT]}, 8'h01);
        // shaper on, proportional pulses
        wr(SERIAL_CONTROL_ADDR, 8'h40);
        wr(IR_SHAPER_CONTROL_ADDR, 8'h6F);
        rchk(IR_SHAPER_CONTROL_ADDR, 8'h6F);
        chk8({7'h00, pin_out}, 8'h00);
        wr(SERIAL_BUFFER_ADDR, 8'h00);
        peer.pulses(400, np);
        chk8(np[7:0], 8'h09);
        peer.send(9'h1F0, 10, 1'b1);
        wait_bit(SC_RXDONE_BIT);
        rchk(SERIAL_BUFFER_ADDR, 8'hF0);
        // shaper on, fixed pulses from the smallest legal divider
        wr(IR_SHAPER_CONTROL_ADDR, 8'h44);
        wr(SERIAL_BUFFER_ADDR, 8'h00);
        peer.pulses(400, np);
        chk8(np[7:0], 8'h09);
        close_out();
    end
endmodule
bind uas_uart uas_uart_asserts #(.TIMER_TICKS(TIMER_TICKS)) u_chk (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .reg_req_i(reg_req_i),
    .channel_two_out_pin_o(channel_two_out_pin_o),
    .reg_rdata_o(reg_rdata_o)
);

// >>> testbench/uas_remote_dev.sv
/* uas_remote_dev: far serial or infrared device.
   assumes: BIT_CLKS core clocks a bit; line driven after rising edges. */
`timescale 1ns/1ns
module uas_remote_dev #(
    parameter int BIT_CLKS = 32 // clocks per bit
)
(
    input wire logic clk_i,
    input wire logic from_dut_i,
    output logic to_dut_o
);
    initial to_dut_o = 1'b1; // idle mark
    // start, v lsb first, stop; ir turns zeros into short pulses
    task automatic send(input logic [8:0] v, input int n, input bit ir);
        logic [10:0] f;
        f = {1'b1, v, 1'b0};
        @(posedge clk_i);
        to_dut_o <= !ir;
        for (int i = 0; i < n; i++)
        begin
            for (int c = 0; c < BIT_CLKS; c++)
            begin
                @(posedge clk_i);
                to_dut_o <= ir ? (!f[i] && c < 6) : f[i];
            end
        end
        @(posedge clk_i);
        to_dut_o <= !ir;
    endtask
    // short false start
    task automatic glitch(input int n);
        repeat (n) @(posedge clk_i) to_dut_o <= 1'b0;
        @(posedge clk_i);
        to_dut_o <= 1'b1;
    endtask
    // catch n bits after a start bit, at bit centres
    task automatic get(input int n, output logic [9:0] v, output bit ok);
        int t;
        v = '0;
        t = 0;
        while (from_dut_i !== 1'b0 && t < 4000)
        begin
            @(posedge clk_i);
            t++;
        end
        ok = t < 4000;
        repeat (BIT_CLKS / 2) @(posedge clk_i);
        for (int i = 0; i < n; i++)
        begin
            repeat (BIT_CLKS) @(posedge clk_i);
            v[i] = from_dut_i;
        end
    endtask
    // count rising edges over a window
    task automatic pulses(input int clks, output int cnt);
        logic last;
        cnt = 0;
        last = from_dut_i;
        repeat (clks)
        begin
            @(negedge clk_i);
            if (from_dut_i && !last)
                cnt++;
            last = from_dut_i;
        end
    endtask
endmodule

// >>> testbench/uas_uart_asserts.sv
/* uas_uart_asserts: port checks for the async serial block.
   assumes: bound to uas_uart; one tick every second clock. */
`timescale 1ns/1ns
module uas_uart_asserts
    import uas_pkg::*;
#(
    parameter int TIMER_TICKS = 1 // rollovers per tick
)
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire uas_reg_req_s reg_req_i,
    input wire logic channel_two_out_pin_o,
    input wire logic [7:0] reg_rdata_o
);
    logic [6:0] irc_q; // shaper control shadow
    logic [7:0] ctl_q; // serial control shadow
    logic fix32; // fixed /32 rate, shaper off
    logic prop_ir; // ten-bit, proportional shaper
    logic mapped; // address decodes
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);
    // shadows follow software writes
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            irc_q <= IR_SHAPER_CONTROL_RST[6:0];
            ctl_q <= SERIAL_CONTROL_RST;
        end
        else if (reg_req_i.wr && reg_req_i.addr == IR_SHAPER_CONTROL_ADDR)
            irc_q <= reg_req_i.wdata[6:0];
        else if (reg_req_i.wr && reg_req_i.addr == SERIAL_CONTROL_ADDR)
            ctl_q <= reg_req_i.wdata;
    end
    assign fix32 = ctl_q[7:6] == 2'h2 && !ctl_q[4] && !irc_q[IRC_ENABLE_BIT];
    assign prop_ir = ctl_q[7:6] == 2'h1 && irc_q[IRC_ENABLE_BIT] && irc_q[IRC_PULSE_BIT];
    assign mapped = reg_req_i.addr inside {IR_SHAPER_CONTROL_ADDR, SERIAL_CONTROL_ADDR,
        SERIAL_BUFFER_ADDR};
    // a bit lasts at least sixteen clocks
    sequence s_low_run;
        !channel_two_out_pin_o [*8] ##8 !channel_two_out_pin_o;
    endsequence
    sequence s_high_run;
        channel_two_out_pin_o [*8] ##8 channel_two_out_pin_o;
    endsequence
    property p_rst_idle;
        $fell(rst_i) |-> channel_two_out_pin_o;
    endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("pin low after reset");
    property p_ctl_rd;
        reg_req_i.rd && reg_req_i.addr == IR_SHAPER_CONTROL_ADDR
        |=> reg_rdata_o == {1'h0, $past(irc_q)};
    endproperty
    a_ctl_rd: assert property (p_ctl_rd) else $error("shaper control read");
    property p_unmapped;
        reg_req_i.rd && !mapped |=> reg_rdata_o == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_hold;
        !reg_req_i.rd |=> $stable(reg_rdata_o);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_tx_start;
        reg_req_i.wr && reg_req_i.addr == SERIAL_BUFFER_ADDR && fix32
        |-> ##[1:40] !channel_two_out_pin_o;
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("no start bit");
    property p_low_run;
        $fell(channel_two_out_pin_o) && fix32 |-> s_low_run;
    endproperty
    a_low_run: assert property (p_low_run) else $error("short low bit");
    property p_high_run;
        $rose(channel_two_out_pin_o) && fix32 |-> s_high_run;
    endproperty
    a_high_run: assert property (p_high_run) else $error("short high bit");
    property p_ir_pulse;
        $rose(channel_two_out_pin_o) && prop_ir
        |-> channel_two_out_pin_o [*5] ##[1:2] !channel_two_out_pin_o;
    endproperty
    a_ir_pulse: assert property (p_ir_pulse) else $error("ir pulse width");
endmodule
